// File: bench/sar_adc_ctrl_monitor.sv
`timescale 1ns/1ps
module sar_adc_ctrl_monitor
  import sar_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DEFAULT
)(
  // clocks and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic conv_clk,
  // host pins
  input wire logic sample_strobe,
  input wire logic cal_req,
  // outputs
  input wire logic busy,
  input wire logic serial_result_out,
  input wire logic bit_strobe
);
  int   pulse_q;
  int   bits_q;
  int   idle_q;
  logic cal_q;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // link edges seen from the system clock
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pulse_q <= 0;
      bits_q  <= 0;
      idle_q  <= 0;
      cal_q   <= 1'b1;
    end
    else
    begin
      pulse_q <= (!busy || cal_req) ? 0 : pulse_q + int'($rose(conv_clk));
      bits_q  <= $rose(busy) ? 0 : bits_q + int'($rose(bit_strobe));
      idle_q  <= busy ? 0 : idle_q + int'(idle_q < 40);
      cal_q   <= cal_req || (cal_q && busy);
    end
  end

  sequence s_launch;
    !busy [*4] ##[1:10] busy;
  endsequence

  sequence s_idle;
    !busy ##1 !busy;
  endsequence

  AST_CAL_BUSY:
    assert property (cal_req |=> busy)
    else $error("busy low at cal");
  AST_CAL_LEN:
    assert property (cal_q && pulse_q < CAL_CYCLES |=> busy)
    else $error("cal ended early");
  AST_CAL_END:
    assert property (cal_q && pulse_q == CAL_CYCLES |-> ##[0:8] !busy)
    else $error("cal ended late");
  AST_BUSY_HOLD:
    assert property (busy && !cal_q && pulse_q < CONV_PULSES |=> busy)
    else $error("busy dropped early");
  AST_BUSY_END:
    assert property (busy && !cal_q && pulse_q == CONV_PULSES
                     |-> ##[0:8] !busy)
    else $error("busy held too long");
  AST_LAUNCH:
    assert property ($fell(sample_strobe) && idle_q > 15 && !cal_req
                     |-> s_launch)
    else $error("no busy after strobe");
  AST_BITS:
    assert property ($fell(busy) && !cal_q |=> bits_q == RES_BITS)
    else $error("bit strobe count");
  AST_HOLD:
    assert property (s_idle |-> $stable(serial_result_out)
                     && $stable(bit_strobe))
    else $error("output moved idle");
endmodule

bind sar_adc_ctrl sar_adc_ctrl_monitor #(.CAL_CYCLES(CAL_CYCLES)) mon_u (
  .clock(clock),
  .reset(reset),
  .conv_clk(conv_clk),
  .sample_strobe(sample_strobe),
  .cal_req(cal_req),
  .busy(busy),
  .serial_result_out(serial_result_out),
  .bit_strobe(bit_strobe)
);

// File: bench/sar_adc_ctrl_tb.sv
`timescale 1ns/1ps
module sar_adc_ctrl_tb;
  import sar_pkg::*;
  localparam int CAL = 20;

`define CHK(n, x, g) \
  begin \
    check_count++; \
    if ((g) !== (x)) \
    begin \
      num_errors++; \
      $display("BAD %s exp %h got %h", n, x, g); \
    end \
  end

  logic                    clock;
  logic                    reset;
  logic                    cal_req;
  logic signed [VIN_W-1:0] vin_code;
  logic                    busy;
  logic                    serial_result_out;
  logic                    bit_strobe;
  logic                    conv_clk;
  logic                    sample_strobe;
  logic [15:0]             exp_q[$];
  logic [15:0]             sh;
  logic [15:0]             e;
  int                      nb = 0;
  int                      num_errors = 0;
  int                      check_count = 0;
  logic signed [VIN_W-1:0] fix[7] = '{18'sh1_0000, 18'sh0_7fff,
    18'sh2_0000, 18'sh3_8000, 18'sh0_0000, 18'sh3_ffff, 18'sh0_0001};

  sar_adc_ctrl #(.CAL_CYCLES(CAL)) dut_u (
    .clock(clock),
    .reset(reset),
    .conv_clk(conv_clk),
    .sample_strobe(sample_strobe),
    .cal_req(cal_req),
    .vin_code(vin_code),
    .busy(busy),
    .serial_result_out(serial_result_out),
    .bit_strobe(bit_strobe)
  );

  sar_host_model host_u (
    .clock(clock),
    .busy(busy),
    .conv_clk(conv_clk),
    .sample_strobe(sample_strobe)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [15:0] sat(input logic signed [VIN_W-1:0] v);
    if (v >= POS_FULL_SCALE)
      return 16'h7fff;
    if (v <= NEG_FULL_SCALE)
      return 16'h8000;
    return v[15:0];
  endfunction

  // result collector, restarted by a calibrate request
  always @(posedge bit_strobe or posedge cal_req)
  begin
    if (cal_req)
      nb = 0;
    else
    begin
      sh = {sh[14:0], serial_result_out};
      nb++;
      if (nb == RES_BITS)
      begin
        nb = 0;
        e = exp_q.pop_front();
        `CHK("result", e, sh)
      end
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic calib();
    host_u.pulses(CAL - 1, 1'b0);
    repeat (10) @(posedge clock);
    `CHK("cal busy", 1'b1, busy)
    host_u.pulses(1, 1'b0);
    repeat (10) @(posedge clock);
    `CHK("cal done", 1'b0, busy)
  endtask

  task automatic conv(input logic signed [VIN_W-1:0] v, input bit early);
    bit ok;
    @(posedge clock) vin_code <= v;
    exp_q.push_back(sat(v));
    host_u.convert(early, ok);
    `CHK("handshake", 1'b1, ok)
  endtask

  initial
  begin
    bit         ok;
    logic [1:0] s;
    reset    = 1'b1;
    cal_req  = 1'b0;
    vin_code = '0;
    void'($urandom(32'h0cf6));
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    calib();
    $display("test calibration ended");
    foreach (fix[i])
      conv(fix[i], i == 3);
    s = {serial_result_out, bit_strobe};
    host_u.pulses(3, 1'b0);
    repeat (5) @(posedge clock);
    `CHK("idle hold", s, {serial_result_out, bit_strobe})
    $display("test coding ended");
    repeat (4)
      conv(VIN_W'($urandom), 1'b1);
    $display("test continuous ended");
    fork
      host_u.convert(1'b0, ok);
      begin
        repeat (100) @(posedge clock);
        cal_req <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK("abort busy", 1'b1, busy)
      end
    join
    `CHK("abort", 1'b0, ok)
    cal_req <= 1'b0;
    calib();
    conv(18'sh0_1234, 1'b0);
    $display("test abort ended");
    `CHK("pending", 0, exp_q.size())
    close_out();
  end
endmodule

// File: bench/sar_host_model.sv
`timescale 1ns/1ps
module sar_host_model
  import sar_pkg::*;
(
  // system clock
  input  wire logic clock,
  // device status
  input  wire logic busy,
  // link pins
  output logic      conv_clk,
  output logic      sample_strobe
);
  initial conv_clk = 1'b0;
  initial sample_strobe = 1'b0;

  // link clock stands still between bursts
  task automatic pulses(input int n, input bit early);
    #7;
    for (int i = 0; i < n; i++)
    begin
      conv_clk = 1'b1;
      #15;
      conv_clk = 1'b0;
      if (early && i == n - 2)
        @(posedge clock) sample_strobe <= 1'b1;
      #15;
    end
  endtask

  task automatic convert(input bit early, output bit ok);
    int w;
    @(posedge clock) sample_strobe <= 1'b1;
    repeat (20) @(posedge clock);
    sample_strobe <= 1'b0;
    for (w = 0; w < 40 && !busy; w++)
      @(posedge clock);
    ok = busy;
    repeat (40) @(posedge clock);
    pulses(CONV_PULSES, early);
    for (w = 0; w < 40 && busy; w++)
      @(posedge clock);
    ok &= !busy;
  endtask
endmodule

// File: hw/cdc_sync.sv
`timescale 1ns/1ps
module cdc_sync
  import sar_pkg::*;
#(
  parameter int W   = 1,
  parameter bit RST = 1'b0
)(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // crossing
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      meta_q   <= {W{RST}};
      sync_out <= {W{RST}};
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// File: hw/delay_timer.sv
`timescale 1ns/1ps
module delay_timer
  import sar_pkg::*;
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // control
  input  wire logic             start,
  input  wire logic [TMR_W-1:0] load,
  output logic                  fire
);

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;
  logic             fire_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    fire_d = 1'b0;
    if (start)
      cnt_d = load;
    else if (cnt_q != '0)
    begin
      cnt_d  = cnt_q - TMR_ONE;
      fire_d = (cnt_q == TMR_ONE);
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      cnt_q <= '0;
      fire  <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      fire  <= fire_d;
    end
  end

endmodule

// File: hw/sar_adc_ctrl.sv
// Operation
// - acquisition then exactly 17 conversion clock pulses run 16-bit approximation.
// - capture input after strobe falls, only when busy is low.
// - strobe fall commits conversion; strobe ignored until conversion completes.
// - clock pulses before the first clock delay are ignored.
// - busy rises a set delay after strobe falls, drops at completion.
// - result sent serially, twos complement, most significant bit first.
// - after busy falls, clocks ignored and serial outputs hold.
// - strobe accepted again about 100 ns after busy falls, for continuous conversion.
// - strobe already high at 17th edge restarts acquisition about 100 ns later.
// - comparator decides on rising clock edge; short final pulse is fine.
// - out-of-range inputs saturate to full-scale twos complement codes.
// - calibrate request asynchronously resets logic, aborts work, forces busy high.
// - calibration starts on request fall, ends after 85,532 clocks, busy low.
`timescale 1ns/1ps
module sar_adc_ctrl
  import sar_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DEFAULT
)(
  // system clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset,
  // conversion clock from host
  input  wire logic                    conv_clk,
  // host control pins
  input  wire logic                    sample_strobe,
  input  wire logic                    cal_req,
  // digitised front-end level
  input  wire logic signed [VIN_W-1:0] vin_code,
  // status and serial result
  output logic                         busy,
  output logic                         serial_result_out,
  output logic                         bit_strobe
);

  logic                 core_rst;
  logic                 sample_s;
  logic [VIN_W-1:0]     vin_s;
  logic                 done_s;
  logic                 cal_s;
  logic                 tmr_start;
  logic [TMR_W-1:0]     tmr_load;
  logic                 tmr_fire;
  logic                 fall;

  ctl_state_t           state_q;
  ctl_state_t           state_d;
  logic                 sample_hist_q;
  logic                 conv_busy_q;
  logic                 conv_busy_d;
  logic                 busy_d;
  logic                 start_tgl_q;
  logic                 start_tgl_d;
  logic [RES_BITS-1:0]  word_q;
  logic [RES_BITS-1:0]  word_d;

  logic                 ack_q;
  logic                 ack_d;
  logic [CNT_W-1:0]     cnt_q;
  logic [CNT_W-1:0]     cnt_d;
  logic [RES_BITS-1:0]  acc_q;
  logic [RES_BITS-1:0]  acc_d;
  logic                 last_bit_q;
  logic                 last_bit_d;
  logic                 data_d;
  logic                 present_q;
  logic                 present_d;
  logic                 done_tgl_q;
  logic                 done_tgl_d;
  logic                 rise_tgl_q;
  logic                 fall_tgl_q;
  logic                 fall_tgl_d;
  logic                 cal_busy_q;
  logic                 cal_busy_d;
  logic [CAL_W-1:0]     cal_cnt_q;
  logic [CAL_W-1:0]     cal_cnt_d;
  logic                 active;
  logic [RES_BITS-1:0]  target;
  logic [RES_BITS-1:0]  trial;

  function automatic logic [RES_BITS-1:0] saturate(
    input logic signed [VIN_W-1:0] v);
    if (v >= POS_FULL_SCALE)
      return POS_FULL_SCALE[RES_BITS-1:0];
    else if (v <= NEG_FULL_SCALE)
      return NEG_FULL_SCALE[RES_BITS-1:0];
    else
      return v[RES_BITS-1:0];
  endfunction

  function automatic logic [RES_BITS-1:0] weight(
    input logic [CNT_W-1:0] step);
    return ONE_LSB << (LAST_DECIDE_CNT - CNT_W'(1) - step);
  endfunction

  // calibrate request doubles as an asynchronous reset
  assign core_rst = reset | cal_req;

  // ---------------- system clock domain ----------------

  cdc_sync #(.W(1), .RST(1'b0)) u_sample_sync
  (
    .clock    (clock),
    .reset    (core_rst),
    .async_in (sample_strobe),
    .sync_out (sample_s)
  );

  cdc_sync #(.W(VIN_W), .RST(1'b0)) u_vin_sync
  (
    .clock    (clock),
    .reset    (core_rst),
    .async_in (vin_code),
    .sync_out (vin_s)
  );

  cdc_sync #(.W(1), .RST(1'b0)) u_done_sync
  (
    .clock    (clock),
    .reset    (core_rst),
    .async_in (done_tgl_q),
    .sync_out (done_s)
  );

  cdc_sync #(.W(1), .RST(1'b1)) u_cal_sync
  (
    .clock    (clock),
    .reset    (core_rst),
    .async_in (cal_busy_q),
    .sync_out (cal_s)
  );

  delay_timer u_timer
  (
    .clock (clock),
    .reset (core_rst),
    .start (tmr_start),
    .load  (tmr_load),
    .fire  (tmr_fire)
  );

  assign fall = sample_hist_q & ~sample_s;

  always_comb
  begin
    state_d     = state_q;
    conv_busy_d = conv_busy_q;
    start_tgl_d = start_tgl_q;
    word_d      = word_q;
    tmr_start   = 1'b0;
    tmr_load    = STB_CYC;
    case (state_q)
      S_IDLE:
      begin
        // strobe only heard while idle and calibrated
        if (fall && !cal_s)
        begin
          word_d    = saturate(vin_s);
          tmr_start = 1'b1;
          tmr_load  = STB_CYC;
          state_d   = S_BUSYWAIT;
        end
      end
      S_BUSYWAIT:
      begin
        if (tmr_fire)
        begin
          conv_busy_d = 1'b1;
          tmr_start   = 1'b1;
          tmr_load    = ARM_CYC;
          state_d     = S_ARMWAIT;
        end
      end
      S_ARMWAIT:
      begin
        // link side starts counting pulses only after this
        if (tmr_fire)
        begin
          start_tgl_d = ~start_tgl_q;
          state_d     = S_CONV;
        end
      end
      S_CONV:
      begin
        if (done_s == start_tgl_q)
        begin
          conv_busy_d = 1'b0;
          tmr_start   = 1'b1;
          tmr_load    = RESTART_CYC;
          state_d     = S_RESUME;
        end
      end
      S_RESUME:
      begin
        // tracking resumes shortly after the last pulse
        if (tmr_fire)
          state_d = S_IDLE;
      end
      default:
        state_d = S_IDLE;
    endcase
    busy_d = cal_s | conv_busy_d;
  end

  always_ff @(posedge clock or posedge core_rst)
  begin
    if (core_rst)
    begin
      state_q       <= S_IDLE;
      sample_hist_q <= 1'b0;
      conv_busy_q   <= 1'b0;
      busy          <= 1'b1;
      start_tgl_q   <= 1'b0;
      word_q        <= '0;
    end
    else
    begin
      state_q       <= state_d;
      sample_hist_q <= sample_s;
      conv_busy_q   <= conv_busy_d;
      busy          <= busy_d;
      start_tgl_q   <= start_tgl_d;
      word_q        <= word_d;
    end
  end

  // ---------------- conversion clock domain ----------------
  // start toggle and word only change before the first clock delay ends,
  // while the host holds the conversion clock still, so they are stable

  assign active = (start_tgl_q != ack_q) && !cal_busy_q;
  assign target = word_q ^ MSB_FLIP;
  assign trial  = acc_q | weight(cnt_q);

  always_comb
  begin
    ack_d      = ack_q;
    cnt_d      = cnt_q;
    acc_d      = acc_q;
    last_bit_d = last_bit_q;
    data_d     = serial_result_out;
    present_d  = 1'b0;
    done_tgl_d = done_tgl_q;
    fall_tgl_d = fall_tgl_q;
    cal_busy_d = cal_busy_q;
    cal_cnt_d  = cal_cnt_q;
    if (cal_busy_q)
    begin
      cal_cnt_d = cal_cnt_q - CAL_ONE;
      if (cal_cnt_q == CAL_ONE)
        cal_busy_d = 1'b0;
    end
    else if (active)
    begin
      // bit strobe only falls while a conversion runs
      fall_tgl_d = rise_tgl_q;
      if (cnt_q < LAST_DECIDE_CNT)
      begin
        // one comparator decision per rising edge
        last_bit_d = (target >= trial);
        if (target >= trial)
          acc_d = trial;
      end
      if (cnt_q != '0)
      begin
        // msb inverted: offset binary to twos complement
        data_d    = last_bit_q ^ (cnt_q == FIRST_OUT_CNT);
        present_d = 1'b1;
      end
      if (cnt_q == LAST_PULSE_CNT)
      begin
        ack_d      = start_tgl_q;
        done_tgl_d = start_tgl_q;
        cnt_d      = '0;
        acc_d      = '0;
      end
      else
        cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge conv_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      ack_q             <= 1'b0;
      cnt_q             <= '0;
      acc_q             <= '0;
      last_bit_q        <= 1'b0;
      serial_result_out <= 1'b0;
      present_q         <= 1'b0;
      done_tgl_q        <= 1'b0;
      fall_tgl_q        <= 1'b0;
      cal_busy_q        <= 1'b1;
      cal_cnt_q         <= CAL_W'(CAL_CYCLES);
    end
    else
    begin
      ack_q             <= ack_d;
      cnt_q             <= cnt_d;
      acc_q             <= acc_d;
      last_bit_q        <= last_bit_d;
      serial_result_out <= data_d;
      present_q         <= present_d;
      done_tgl_q        <= done_tgl_d;
      fall_tgl_q        <= fall_tgl_d;
      cal_busy_q        <= cal_busy_d;
      cal_cnt_q         <= cal_cnt_d;
    end
  end

  // bit strobe rises mid-pulse, after the data has settled
  always_ff @(negedge conv_clk or posedge core_rst)
  begin
    if (core_rst)
      rise_tgl_q <= 1'b0;
    else if (present_q)
      rise_tgl_q <= ~rise_tgl_q;
  end

  assign bit_strobe = rise_tgl_q ^ fall_tgl_q;

endmodule

// File: hw/sar_pkg.sv
package sar_pkg;

  // converter geometry
  localparam int RES_BITS    = 16;
  localparam int CONV_PULSES = 17;
  localparam int CNT_W       = 5;
  localparam int VIN_W       = 18;
  localparam int TMR_W       = 8;
  localparam int CAL_W       = 17;

  // calibration length in conversion clock cycles
  localparam int CAL_CYCLES_DEFAULT = 85532;

  localparam logic [CNT_W-1:0] FIRST_OUT_CNT = 5'h01;
  localparam logic [CNT_W-1:0] LAST_PULSE_CNT = CNT_W'(CONV_PULSES - 1);
  localparam logic [CNT_W-1:0] LAST_DECIDE_CNT = CNT_W'(RES_BITS);
  localparam logic [RES_BITS-1:0] MSB_FLIP = 16'h8000;
  localparam logic [RES_BITS-1:0] ONE_LSB  = 16'h0001;
  localparam logic signed [VIN_W-1:0] POS_FULL_SCALE = 18'sh0_7fff;
  localparam logic signed [VIN_W-1:0] NEG_FULL_SCALE = 18'sh3_8000;
  localparam logic [CAL_W-1:0] CAL_ONE = 17'h0_0001;
  localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;

  // timing, system clock rate and delays in ns
  localparam int CLOCK_MHZ            = 100;
  localparam int STROBE_TO_BUSY_NS    = 50;
  localparam int FIRST_CLOCK_DELAY_NS = 200;
  localparam int RESTART_NS           = 100;

  function automatic int cycles_up(input int ns);
    int c;
    c = (ns * CLOCK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cycles_down(input int ns);
    int c;
    c = (ns * CLOCK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [TMR_W-1:0] STB_CYC =
    TMR_W'(cycles_down(STROBE_TO_BUSY_NS));
  localparam logic [TMR_W-1:0] ARM_CYC =
    TMR_W'(cycles_up(FIRST_CLOCK_DELAY_NS) - cycles_down(STROBE_TO_BUSY_NS));
  localparam logic [TMR_W-1:0] RESTART_CYC =
    TMR_W'(cycles_down(RESTART_NS));

  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_BUSYWAIT = 3'b001,
    S_ARMWAIT  = 3'b011,
    S_CONV     = 3'b010,
    S_RESUME   = 3'b110
  } ctl_state_t;

endpackage
